// File: shared/fpr_pkg.sv
`default_nettype none

package fpr_pkg;

  // ----------------------------------------------------------------------
  // Register word indices and address width
  // ----------------------------------------------------------------------
  localparam logic [3:0] IDX_PA_DIR = 4'h5;
  localparam logic [3:0] IDX_PB_DIR = 4'h6;
  localparam logic [3:0] IDX_PA_PULL = 4'h9;
  localparam logic [3:0] IDX_PS0_VIEW = 4'hA;
  localparam logic [3:0] IDX_PB_OD = 4'hC;
  localparam logic [3:0] IDX_CMP_SEL = 4'hE;
  localparam logic [3:0] IDX_PWR_CTL = 4'hF;
  // Extra control word for instruction strobes and detector input view
  localparam logic [3:0] IDX_IRQ_CMD = 4'h0;
  localparam int ADDR_W = 6;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int PWR_TIMER_RUN = 0;
  localparam int PWR_SPARE_ONE = 1;
  localparam int PWR_LOWV_LSB = 2;
  localparam int PWR_SPARE_FIVE = 5;
  localparam int PWR_LOWV_OUT = 6;
  localparam int PWR_GIE = 7;
  localparam int PULL_A5_BIT = 5;
  localparam int CMD_IRQ_ON = 0;
  localparam int CMD_IRQ_OFF = 1;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_PA_DIR = 8'hFF;
  localparam logic [5:0] RST_PB_DIR = 6'h3F;
  localparam logic [7:0] RST_PA_PULL = 8'hFF;
  localparam logic [7:0] RST_PS0_VIEW = 8'hFF;
  localparam logic [5:0] RST_PB_OD = 6'h00;
  localparam logic [3:0] RST_CMP_PAD = 4'h0;
  localparam logic [3:0] RST_CMP_REF = 4'hC;
  localparam logic RST_TIMER_RUN = 1'b1;
  localparam logic [2:0] RST_LOWV_SEL = 3'h7;
  localparam logic RST_SPARE = 1'b0;
  localparam logic RST_GIE = 1'b0;
  // Stable value returned by unimplemented bits
  localparam logic [1:0] UNIMP_BITS = 2'h0;

  // Comparator routing modes
  typedef enum logic [1:0] {
    FPR_CMP_P2P,
    FPR_CMP_P2V,
    FPR_CMP_NONE
  } fpr_cmp_mode_t;

endpackage

`default_nettype wire

// File: src/fpr_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Three-stage synchroniser; output updates when stages two and three agree
module fpr_sync (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Data
  input wire logic async_in,
  output var logic sync_out
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // Three flip-flop chain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else if (clk_en) begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Accept value once later stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_out <= 1'b0;
    end else if (clk_en && (s2_reg == s3_reg)) begin
      sync_out <= s3_reg;
    end
  end

endmodule

`default_nettype wire

// File: src/fpr_cmp_route.sv
`timescale 1ns/1ps
`default_nettype none

// Registered comparator input routing decode
module fpr_cmp_route (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Selection fields
  input wire logic [3:0] pad_sel,
  input wire logic [3:0] ref_sel,
  // Routing
  output var logic pad_to_pad_mode,
  output var logic pad_to_voltage_mode,
  output var logic [3:0] noninv_pad_onehot,
  output var logic [3:0] inv_pad_onehot,
  output var logic [3:0] ref_sixteenths
);
  import fpr_pkg::*;

  fpr_cmp_mode_t mode;
  logic [3:0] np_next;
  logic [3:0] ip_next;

  // Mode and pad decode
  always_comb begin
    mode = (ref_sel == 4'h0) ? FPR_CMP_P2P : FPR_CMP_P2V;
    np_next = 4'h0;
    ip_next = 4'h0;
    if (pad_sel[3:2] == 2'h0) begin
      np_next[pad_sel[1:0]] = 1'b1;
      if (mode == FPR_CMP_P2P) begin
        ip_next[{pad_sel[1], ~pad_sel[0]}] = 1'b1;
      end
    end
  end

  // Registered routing outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_to_pad_mode <= 1'b0;
      pad_to_voltage_mode <= 1'b1;
      noninv_pad_onehot <= 4'h1;
      inv_pad_onehot <= 4'h0;
      ref_sixteenths <= RST_CMP_REF;
    end else if (clk_en) begin
      pad_to_pad_mode <= (mode == FPR_CMP_P2P);
      pad_to_voltage_mode <= (mode == FPR_CMP_P2V);
      noninv_pad_onehot <= np_next;
      inv_pad_onehot <= ip_next;
      ref_sixteenths <= ref_sel;
    end
  end

endmodule

`default_nettype wire

// File: src/fpr_regs.sv
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

//
// Summary of operation
// - Port A direction bits: 1 input, reset ones
// - Port B six direction bits, reset ones
// - Port A pull-up off bits, active low
// - Bit five drives pin A5 pull-down instead
// - Read-only live prescaler count view, reset ones
// - Port B open-drain bits, reset zero
// - Zero reference select means pad-to-pad mode
// - Reference n selects n sixteenths supply
// - Pad codes 0-3 route A0..A3 non-inverting
// - Pad-to-pad pairs A0/A1, A1/A0, A2/A3, A3/A2
// - Power bit zero runs timer zero
// - Threshold field bits 4:2, reset 111
// - Bit six shows detector output, read-only
// - Bit seven global interrupt enable, reset zero
// - Enable/disable instructions set and clear it
// - Bits one and five plain storage
//
module fpr_regs (
  // Clock, reset and enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fpr_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core instruction strobes
  input wire logic irq_on_instr,
  input wire logic irq_off_instr,
  // Live inputs from surrounding logic
  input wire logic [7:0] prescaler0_count,
  input wire logic lowv_detect_raw,
  // Port controls
  output logic [7:0] port_a_pin_dir,
  output logic [5:0] port_b_pin_dir,
  output logic [7:0] port_a_pullup_off,
  output logic pin_a5_pulldown_off,
  output logic [5:0] port_b_open_drain_en,
  // Comparator routing
  output logic pad_to_pad_mode,
  output logic pad_to_voltage_mode,
  output logic [3:0] cmp_noninv_pad,
  output logic [3:0] cmp_inv_pad,
  output logic [3:0] cmp_ref_sixteenths,
  // Power control
  output logic timer_zero_run,
  output logic [2:0] lowv_threshold_sel,
  output logic global_irq_enable
);
  import fpr_pkg::*;

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [7:0] pa_dir_reg;
  logic [5:0] pb_dir_reg;
  logic [7:0] pa_pull_reg;
  logic [5:0] pb_od_reg;
  logic [3:0] cmp_pad_reg;
  logic [3:0] cmp_ref_reg;
  logic spare_one_reg;
  logic spare_five_reg;
  logic [2:0] lowv_sel_reg;
  logic timer_run_reg;
  logic gie_reg;
  logic [7:0] ps0_view_reg;
  logic lowv_sync;
  logic [7:0] rd_next;
  logic wr_hit;
  logic rd_hit;
  logic addr_ok;
  logic [3:0] idx;
  // Per-register write strobes
  logic pa_dir_wr;
  logic pb_dir_wr;
  logic pa_pull_wr;
  logic pb_od_wr;
  logic cmp_wr;
  logic pwr_wr;
  logic cmd_on_wr;
  logic cmd_off_wr;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  // Indices that answer without error
  function automatic logic known_index(input logic [3:0] i);
    return (i == IDX_PA_DIR) || (i == IDX_PB_DIR) || (i == IDX_PA_PULL) ||
      (i == IDX_PS0_VIEW) || (i == IDX_PB_OD) || (i == IDX_CMP_SEL) ||
      (i == IDX_PWR_CTL) || (i == IDX_IRQ_CMD);
  endfunction

  // Write strobe for one register index
  function automatic logic reg_hit(input logic en, input logic [3:0] at,
                                   input logic [3:0] want);
    return en && (at == want);
  endfunction

  // Word index from byte address
  assign idx = paddr[5:2];
  assign addr_ok = known_index(idx) && (paddr[1:0] == 2'h0);
  assign wr_hit = clk_en && psel && penable && pwrite && addr_ok;
  assign rd_hit = clk_en && psel && !penable && !pwrite;

  // One strobe per writable register, two for the command word; only the access edge of a mapped write
  assign pa_dir_wr = reg_hit(wr_hit, idx, IDX_PA_DIR);
  assign pb_dir_wr = reg_hit(wr_hit, idx, IDX_PB_DIR);
  assign pa_pull_wr = reg_hit(wr_hit, idx, IDX_PA_PULL);
  assign pb_od_wr = reg_hit(wr_hit, idx, IDX_PB_OD);
  assign cmp_wr = reg_hit(wr_hit, idx, IDX_CMP_SEL);
  assign pwr_wr = reg_hit(wr_hit, idx, IDX_PWR_CTL);
  assign cmd_on_wr = reg_hit(wr_hit, idx, IDX_IRQ_CMD) && pwdata[CMD_IRQ_ON];
  assign cmd_off_wr = reg_hit(wr_hit, idx, IDX_IRQ_CMD) &&
    pwdata[CMD_IRQ_OFF];

  // Detector output crosses from the analog side
  // Reads of the detector bit lag the pin by three to four cycles
  fpr_sync u_lowv_sync (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .async_in(lowv_detect_raw),
    .sync_out(lowv_sync)
  );

  // ----------------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------------
  // Port A direction; set bit makes the pin an input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_dir_reg <= RST_PA_DIR;
    end else if (pa_dir_wr) begin
      pa_dir_reg <= pwdata[7:0];
    end
  end

  // Port B direction; the two top bits have no storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pb_dir_reg <= RST_PB_DIR;
    end else if (pb_dir_wr) begin
      pb_dir_reg <= pwdata[5:0];
    end
  end

  // Port A pull control; cleared bit turns the pull on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_pull_reg <= RST_PA_PULL;
    end else if (pa_pull_wr) begin
      pa_pull_reg <= pwdata[7:0];
    end
  end

  // Port B open-drain enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pb_od_reg <= RST_PB_OD;
    end else if (pb_od_wr) begin
      pb_od_reg <= pwdata[5:0];
    end
  end

  // Comparator select fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_pad_reg <= RST_CMP_PAD;
      cmp_ref_reg <= RST_CMP_REF;
    end else if (cmp_wr) begin
      cmp_pad_reg <= pwdata[7:4];
      cmp_ref_reg <= pwdata[3:0];
    end
  end

  // Timer zero run bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_run_reg <= RST_TIMER_RUN;
    end else if (pwr_wr) begin
      timer_run_reg <= pwdata[PWR_TIMER_RUN];
    end
  end

  // Spare bits: storage only, nothing but the read mux reads them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spare_one_reg <= RST_SPARE;
      spare_five_reg <= RST_SPARE;
    end else if (pwr_wr) begin
      spare_one_reg <= pwdata[PWR_SPARE_ONE];
      spare_five_reg <= pwdata[PWR_SPARE_FIVE];
    end
  end

  // Detector threshold; the detector bit itself is never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lowv_sel_reg <= RST_LOWV_SEL;
    end else if (pwr_wr) begin
      lowv_sel_reg <= pwdata[PWR_LOWV_LSB +: 3];
    end
  end

  // Global interrupt enable: instructions first, then bus
  // An instruction in the same cycle as a bus write keeps its effect,
  // so code that just disabled interrupts is never overruled by the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gie_reg <= RST_GIE;
    end else if (clk_en) begin
      if (irq_on_instr) begin
        gie_reg <= 1'b1;
      end else if (irq_off_instr) begin
        gie_reg <= 1'b0;
      end else if (cmd_on_wr) begin
        gie_reg <= 1'b1;
      end else if (cmd_off_wr) begin
        gie_reg <= 1'b0;
      end else if (pwr_wr) begin
        gie_reg <= pwdata[PWR_GIE];
      end
    end
  end

  // Live prescaler count, sampled each enabled cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps0_view_reg <= RST_PS0_VIEW;
    end else if (clk_en) begin
      ps0_view_reg <= prescaler0_count;
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Read mux; unimplemented bits return a fixed value
  always_comb begin
    rd_next = 8'h00;
    unique case (idx)
      IDX_PA_DIR: rd_next = pa_dir_reg;
      IDX_PB_DIR: rd_next = {UNIMP_BITS, pb_dir_reg};
      IDX_PA_PULL: rd_next = pa_pull_reg;
      IDX_PS0_VIEW: rd_next = ps0_view_reg;
      IDX_PB_OD: rd_next = {UNIMP_BITS, pb_od_reg};
      IDX_CMP_SEL: rd_next = {cmp_pad_reg, cmp_ref_reg};
      IDX_PWR_CTL: rd_next = {gie_reg, lowv_sync, spare_five_reg,
                              lowv_sel_reg, spare_one_reg,
                              timer_run_reg};
      IDX_IRQ_CMD: rd_next = {7'h00, lowv_sync};
      default: rd_next = 8'h00;
    endcase
  end

  // Read data captured in setup phase, stable through access
  // Unmapped or misaligned reads return zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_hit) begin
      prdata <= {24'h00_0000, addr_ok ? rd_next : 8'h00};
    end
  end

  // Ready and error: no wait states, error on unmapped or misaligned address
  // Registered ready keeps the slave off any combinational bus path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
    end
  end

  // ----------------------------------------------------------------------
  // Pin-side controls
  // ----------------------------------------------------------------------
  // Registered port controls
  // Outputs lag their register by one enabled cycle, free of glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_a_pin_dir <= RST_PA_DIR;
      port_b_pin_dir <= RST_PB_DIR;
      port_a_pullup_off <= RST_PA_PULL;
      pin_a5_pulldown_off <= RST_PA_PULL[PULL_A5_BIT];
      port_b_open_drain_en <= RST_PB_OD;
    end else if (clk_en) begin
      port_a_pin_dir <= pa_dir_reg;
      port_b_pin_dir <= pb_dir_reg;
      // Pin A5 has no pull-up: its bit steers the pull-down
      port_a_pullup_off <= pa_pull_reg | 8'h20;
      pin_a5_pulldown_off <= pa_pull_reg[PULL_A5_BIT];
      port_b_open_drain_en <= pb_od_reg;
    end
  end

  // Registered power controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_zero_run <= RST_TIMER_RUN;
      lowv_threshold_sel <= RST_LOWV_SEL;
      global_irq_enable <= RST_GIE;
    end else if (clk_en) begin
      timer_zero_run <= timer_run_reg;
      lowv_threshold_sel <= lowv_sel_reg;
      global_irq_enable <= gie_reg;
    end
  end

  // Comparator routing decode
  fpr_cmp_route u_cmp_route (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .pad_sel(cmp_pad_reg),
    .ref_sel(cmp_ref_reg),
    .pad_to_pad_mode(pad_to_pad_mode),
    .pad_to_voltage_mode(pad_to_voltage_mode),
    .noninv_pad_onehot(cmp_noninv_pad),
    .inv_pad_onehot(cmp_inv_pad),
    .ref_sixteenths(cmp_ref_sixteenths)
  );

endmodule

`default_nettype wire

// File: sim/fpr_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module fpr_regs_asserts (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Bus and strobes
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fpr_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq_on_instr,
  input wire logic irq_off_instr,
  input wire logic [7:0] prescaler0_count,
  // Controls
  input wire logic [7:0] port_a_pin_dir,
  input wire logic [7:0] port_a_pullup_off,
  input wire logic pad_to_pad_mode,
  input wire logic pad_to_voltage_mode,
  input wire logic [3:0] cmp_noninv_pad,
  input wire logic [3:0] cmp_inv_pad,
  input wire logic [3:0] cmp_ref_sixteenths,
  input wire logic global_irq_enable
);
  import fpr_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // -------------------------------------------------------------
  // Decode and bus steps
  // -------------------------------------------------------------
  logic mapped;
  assign mapped = paddr[1:0] == 2'h0 && paddr[5:2] inside {IDX_IRQ_CMD,
    IDX_PA_DIR, IDX_PB_DIR, IDX_PA_PULL, IDX_PS0_VIEW, IDX_PB_OD,
    IDX_CMP_SEL, IDX_PWR_CTL};
  sequence setup_s;
    psel && !penable && clk_en;
  endsequence
  sequence view_rd_s;
    setup_s ##0 !pwrite && paddr == {IDX_PS0_VIEW, 2'h0};
  endsequence
  sequence dir_wr_s;
    psel && penable && pwrite && clk_en && paddr == {IDX_PA_DIR, 2'h0};
  endsequence
  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  a_ready_once: assert property (setup_s |=> pready ##1 !pready)
    else $error("pready not a single access pulse");
  a_err_decode: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr disagrees with decode");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_view_live: assert property (view_rd_s |=>
    prdata == {24'h0, $past(prescaler0_count, 2)})
    else $error("count view read wrong");
  a_dir_follow: assert property (dir_wr_s ##1 clk_en |=>
    port_a_pin_dir == $past(pwdata[7:0], 2))
    else $error("port A direction did not follow write");
  a_gie_set: assert property (irq_on_instr && clk_en |->
    ##[1:2] global_irq_enable)
    else $error("enable strobe did not set gie");
  a_gie_clear: assert property (irq_off_instr && !irq_on_instr &&
    clk_en |-> ##[1:2] !global_irq_enable)
    else $error("disable strobe did not clear gie");
  a_a5_no_pullup: assert property (port_a_pullup_off[5])
    else $error("pin A5 pull-up enabled");
  a_p2v_route: assert property (pad_to_voltage_mode |->
    !pad_to_pad_mode && cmp_ref_sixteenths != 4'h0 && cmp_inv_pad == 4'h0)
    else $error("pad-to-voltage routing wrong");
  a_p2p_pairs: assert property (pad_to_pad_mode |-> cmp_inv_pad ==
    {cmp_noninv_pad[2], cmp_noninv_pad[3], cmp_noninv_pad[0],
    cmp_noninv_pad[1]})
    else $error("pad-to-pad pair wrong");
endmodule

bind fpr_regs fpr_regs_asserts u_chk (.pclk, .presetn, .clk_en, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .irq_on_instr, .irq_off_instr, .prescaler0_count, .port_a_pin_dir,
  .port_a_pullup_off, .pad_to_pad_mode, .pad_to_voltage_mode,
  .cmp_noninv_pad, .cmp_inv_pad, .cmp_ref_sixteenths, .global_irq_enable);

`default_nettype wire

// File: sim/fpr_regs_test.sv
`timescale 1ns/1ps
`default_nettype none

module fpr_regs_test;
  import fpr_pkg::*;
  logic pclk = 1'h0, presetn = 1'h0, clk_en = 1'h1, psel = 1'h0;
  logic penable = 1'h0, pwrite = 1'h0, irq_on_instr = 1'h0;
  logic irq_off_instr = 1'h0, lowv_detect_raw = 1'h0;
  logic [ADDR_W-1:0] paddr = 6'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h25A0;
  logic pready, pslverr, err, pin_a5_pulldown_off, pad_to_pad_mode;
  logic pad_to_voltage_mode, timer_zero_run, global_irq_enable;
  logic [7:0] prescaler0_count = 8'hFF, port_a_pin_dir, port_a_pullup_off;
  logic [5:0] port_b_pin_dir, port_b_open_drain_en;
  logic [3:0] cmp_noninv_pad, cmp_inv_pad, cmp_ref_sixteenths;
  logic [2:0] lowv_threshold_sel;
  logic [7:0] m [16];
  int num_errors = 0, comparisons = 0;

  // Clock
  always #25 pclk = ~pclk;

  fpr_regs dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq_on_instr, .irq_off_instr,
    .prescaler0_count, .lowv_detect_raw, .port_a_pin_dir, .port_b_pin_dir,
    .port_a_pullup_off, .pin_a5_pulldown_off, .port_b_open_drain_en,
    .pad_to_pad_mode, .pad_to_voltage_mode, .cmp_noninv_pad, .cmp_inv_pad,
    .cmp_ref_sixteenths, .timer_zero_run, .lowv_threshold_sel,
    .global_irq_enable);

  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic bad(input int i);
    return !(i inside {0, 5, 6, 9, 10, 12, 14, 15});
  endfunction
  function automatic logic [7:0] expv(input int i);
    if (i == 10) return prescaler0_count;
    if (i == 15) return m[15] | {1'h0, lowv_detect_raw, 6'h0};
    if (i == 0) return {7'h0, lowv_detect_raw};
    return m[i];
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic model_reset;
    m = '{default: 8'h00};
    m[5] = 8'hFF;
    m[6] = 8'h3F;
    m[9] = 8'hFF;
    m[14] = 8'h0C;
    m[15] = 8'h1D;
  endtask
  // APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [5:0] a,
      input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // Wait as long as it takes; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic wr(input int i, input logic [7:0] d);
    apb(1'h1, 6'(i * 4), {24'h0, d});
    chk(err, bad(i));
    if (i == 6 || i == 12) m[i] = d & 8'h3F;
    else if (i == 15) m[i] = d & 8'hBF;
    else if (i == 0) m[15][7] = d[0] | (m[15][7] & !d[1]);
    else if (!bad(i) && i != 10) m[i] = d;
  endtask
  task automatic rdchk(input int i);
    apb(1'h0, 6'(i * 4), 32'h0);
    chk(rd, {24'h0, expv(i)});
    chk(err, bad(i));
  endtask
  task automatic pins;
    logic [3:0] v;
    logic [3:0] p;
    repeat (2) @(posedge pclk);
    v = m[14][3:0];
    p = m[14][7:4];
    chk(port_a_pin_dir, m[5]);
    chk(port_b_pin_dir, m[6][5:0]);
    chk(port_a_pullup_off, m[9] | 8'h20);
    chk(pin_a5_pulldown_off, m[9][5]);
    chk(port_b_open_drain_en, m[12][5:0]);
    chk({timer_zero_run, lowv_threshold_sel, global_irq_enable},
      {m[15][0], m[15][4:2], m[15][7]});
    chk({pad_to_pad_mode, pad_to_voltage_mode, cmp_ref_sixteenths},
      {v == 4'h0, v != 4'h0, v});
    chk({cmp_noninv_pad, cmp_inv_pad}, {p < 4'h4 ? 4'h1 << p : 4'h0,
      v == 4'h0 ? 4'h1 << (p ^ 4'h1) : 4'h0});
  endtask
  task automatic sweep;
    pins;
    for (int i = 0; i < 16; i++) rdchk(i);
  endtask
  task automatic pulse(input logic on, input logic off, input logic g);
    irq_on_instr <= on;
    irq_off_instr <= off;
    @(posedge pclk);
    irq_on_instr <= 1'h0;
    irq_off_instr <= 1'h0;
    clk_en <= 1'h1;
    m[15][7] = g;
    pins;
    rdchk(15);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // -------------------------------------------------------------
  // Sequence
  // -------------------------------------------------------------
  initial begin
    model_reset;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    sweep;
    for (int k = 0; k < 20; k++) begin
      seed = lfsr(seed);
      lowv_detect_raw <= seed[31];
      prescaler0_count <= seed[15:8];
      for (int i = 0; i < 16; i++) begin
        seed = lfsr(seed);
        // Odd rounds use A6/A7 as crystal pads: their pull-ups stay off
        wr(i, i == 14 ? {k[3:0], k < 16 ? k[3:0] ^ 4'h3 : 4'h0} :
          i == 9 && k[0] ? seed[7:0] | 8'hC0 :
          i == 0 ? {6'h0, seed[0], !seed[0]} : seed[7:0]);
      end
      sweep;
    end
    apb(1'h1, 6'h15, 32'hFF);
    chk(err, 1'h1);
    apb(1'h0, 6'h15, 32'h0);
    chk(rd, 32'h0);
    chk(err, 1'h1);
    pulse(1'h1, 1'h0, 1'h1);
    pulse(1'h0, 1'h1, 1'h0);
    pulse(1'h1, 1'h1, 1'h1);
    clk_en <= 1'h0;
    pulse(1'h0, 1'h1, 1'h1);
    lowv_detect_raw <= 1'h0;
    prescaler0_count <= 8'hFF;
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    model_reset;
    @(posedge pclk);
    sweep;
    tally_and_finish;
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    tally_and_finish;
  end
endmodule

`default_nettype wire
